// ### rtl/cecs_pkg.sv
// package: event codes, unit masks, thermal timing for the event selector
package cecs_pkg;
  localparam logic [7:0] CECS_EV_THERMAL   = 8'h3B;
  localparam logic [7:0] CECS_EV_UNHALTED  = 8'h3C;
  localparam logic [7:0] CECS_EV_CACHE_RD  = 8'h40;
  localparam logic [7:0] CECS_EV_CACHE_WR  = 8'h41;
  localparam logic [7:0] CECS_EV_LOCK_RD   = 8'h42;
  localparam logic [7:0] CECS_UM_THERMAL   = 8'hC0;
  localparam logic [7:0] CECS_UM_CORE      = 8'h00;
  localparam logic [7:0] CECS_UM_BUS       = 8'h01;
  localparam logic [7:0] CECS_UM_SOLE      = 8'h02;
  localparam int         CECS_CLK_HZ       = 40_000_000;
  localparam int         CECS_SAMPLE_US    = 1000;
  localparam int         CECS_SAMPLE_CYC   =
    (CECS_CLK_HZ / 1_000_000) * CECS_SAMPLE_US;
  localparam logic [15:0] CECS_CNT_RST     = 16'h0000;
  localparam int         CECS_CNT_W        = 48;
  localparam logic [CECS_CNT_W-1:0] CECS_COUNT_RST = '0;

  typedef enum logic [1:0] {
    CECS_TH_NORMAL   = 2'b00,
    CECS_TH_THROTTLE = 2'b01
  } cecs_th_state_t;
endpackage

// ### rtl/cecs_sel_if.sv
// interface: selected event code and unit mask toward the source matcher
interface cecs_sel_if;
  logic [7:0] event_code;
  logic [7:0] unit_mask;
  logic [3:0] line_state_mask;
  logic       hit;
  modport src (output event_code, output unit_mask,
               output line_state_mask, input hit);
  modport mat (input event_code, input unit_mask,
               input line_state_mask, output hit);
endinterface

// ### rtl/cecs_match.sv
// matcher: chooses the single qualifying source for the programmed event
module cecs_match
  import cecs_pkg::*;
(
  cecs_sel_if.mat sel,              // selection in, increment out
  input  wire logic       thermal_trip_p, // one-cycle trip pulse
  input  wire logic       core_cyc,       // core cycle, not halted
  input  wire logic       bus_cyc,        // bus edge, not halted
  input  wire logic       sole_bus_cyc,   // bus edge, other core halted
  input  wire logic       rd_p,           // cacheable read pulse
  input  wire logic       wr_p,           // cacheable write pulse
  input  wire logic       lock_p,         // access is locked
  input  wire logic [3:0] line_state      // one-hot line state of access
);
  logic st_ok;
  assign st_ok = |(line_state & sel.line_state_mask);

  always_comb begin
    sel.hit = 1'b0;
    case (sel.event_code)
      CECS_EV_THERMAL: sel.hit = thermal_trip_p; // RQ1
      CECS_EV_UNHALTED: begin
        case (sel.unit_mask)
          CECS_UM_CORE: sel.hit = core_cyc;     // RQ3
          CECS_UM_BUS:  sel.hit = bus_cyc;      // RQ5
          CECS_UM_SOLE: sel.hit = sole_bus_cyc; // RQ6
          default:      sel.hit = 1'b0;         // RQ10
        endcase
      end
      CECS_EV_CACHE_RD: sel.hit = rd_p & ~lock_p & st_ok; // RQ7
      CECS_EV_CACHE_WR: sel.hit = wr_p & ~lock_p & st_ok; // RQ8
      CECS_EV_LOCK_RD:  sel.hit = rd_p & lock_p & st_ok;  // RQ9
      default:          sel.hit = 1'b0;                   // RQ10
    endcase
  end
endmodule

// ### rtl/cecs_top.sv
// top: event sources, thermal throttle and event counter for one core
// Functional notes
// RQ1: count each rise above thermal trip threshold
// RQ2: throttle on trip, sample each millisecond, recover
// RQ3: 3CH/00H counts unhalted core clock cycles
// RQ4: halt starts at halt instruction; halted cycles excluded
// RQ5: 3CH/01H counts unhalted bus clock cycles
// RQ6: 3CH/02H counts bus cycles, other core halted
// RQ7: 40H counts unlocked cacheable reads by state
// RQ8: 41H counts unlocked cacheable writes by state
// RQ9: 42H counts locked cacheable reads by state
// RQ10: count only on matching source, one per occurrence
module cecs_top
  import cecs_pkg::*;
#(
  parameter int SAMPLE_CYC = CECS_SAMPLE_CYC
) (
  input  wire logic                  CLK,            // core clock 40 MHz
  input  wire logic                  RESET_N,        // async reset, low
  input  wire logic [7:0]            EVENT_CODE,     // programmed event
  input  wire logic [7:0]            UNIT_MASK,      // programmed umask
  input  wire logic                  COUNT_EN,       // counter enabled
  input  wire logic                  COUNT_CLR,      // clear counter
  input  wire logic                  OVER_TRIP,      // temp above trip
  input  wire logic                  HALT_EXEC,      // halt instr executes
  input  wire logic                  WAKE,           // leave halt state
  input  wire logic                  OTHER_HALTED,   // other core halted
  input  wire logic                  BUS_CLK,        // bus clock, sampled
  input  wire logic                  RD_VALID,       // cacheable read done
  input  wire logic                  WR_VALID,       // cacheable write done
  input  wire logic                  LOCKED,         // access is locked
  input  wire logic [3:0]            LINE_STATE,     // one-hot M,E,S,I
  output logic [CECS_CNT_W-1:0]      COUNT,          // event count
  output logic                       THROTTLE,       // freq/volt lowered
  output logic                       HALTED          // core halted
);
  // selection toward the matcher; the low mask nibble filters line state
  cecs_sel_if sel ();

  // halt state
  logic                  halted_r;
  logic                  halted_nxt;

  // previous-cycle samples of levels whose rise is an event
  logic                  bus_clk_r;
  logic                  bus_clk_nxt;
  logic                  trip_seen_r;
  logic                  trip_seen_nxt;

  // thermal throttle state, its sample timer and registered output
  cecs_th_state_t        th_r;
  cecs_th_state_t        th_nxt;
  logic [15:0]           tick_r;
  logic [15:0]           tick_nxt;
  logic                  throttle_r;
  logic                  throttle_nxt;

  // event counter
  logic [CECS_CNT_W-1:0] count_r;
  logic [CECS_CNT_W-1:0] count_nxt;

  // per-cycle source strobes
  logic                  trip_p;
  logic                  run;
  logic                  bus_edge;
  logic                  bus_run;
  logic                  sole_run;
  logic                  sample_due;
  logic                  count_inc;

  // rise of a level against its sample from the previous clock
  function automatic logic rise_of(input logic now_v,
                                   input logic was_v);
    return now_v & ~was_v;
  endfunction

  // the core runs unless already halted or halting in this cycle
  function automatic logic core_runs(input logic halted_v,
                                     input logic halt_v);
    return ~halted_v & ~halt_v;
  endfunction

  // next counter value; a clear wins over a coincident increment
  function automatic logic [CECS_CNT_W-1:0] count_step(
      input logic [CECS_CNT_W-1:0] cur_v,
      input logic                  clr_v,
      input logic                  inc_v);
    logic [CECS_CNT_W-1:0] nxt_v;
    nxt_v = cur_v;
    if (clr_v) begin
      nxt_v = CECS_COUNT_RST;
    end else if (inc_v) begin
      nxt_v = cur_v + CECS_CNT_W'(1);                      // RQ10
    end
    return nxt_v;
  endfunction

  assign sel.event_code      = EVENT_CODE;
  assign sel.unit_mask       = UNIT_MASK;
  assign sel.line_state_mask = UNIT_MASK[3:0];

  // halt tracking: halted from the halt instruction's cycle onward;
  // a wake in the same cycle as a halt instruction is ignored
  always_comb begin
    halted_nxt = halted_r;
    if (HALT_EXEC) begin
      halted_nxt = 1'b1;                                   // RQ4
    end else if (WAKE) begin
      halted_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      halted_r <= 1'b0;
    end else begin
      halted_r <= halted_nxt;
    end
  end

  assign run = core_runs(halted_r, HALT_EXEC);             // RQ4

  // level samples for edge detection; each rise of the bus clock seen
  // is one bus cycle, so each of its phases must last a core clock
  always_comb begin
    bus_clk_nxt   = BUS_CLK;
    trip_seen_nxt = OVER_TRIP;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bus_clk_r   <= 1'b0;
      trip_seen_r <= 1'b0;
    end else begin
      bus_clk_r   <= bus_clk_nxt;
      trip_seen_r <= trip_seen_nxt;
    end
  end

  // strobes handed to the matcher, already gated by the halt state
  assign bus_edge = rise_of(BUS_CLK, bus_clk_r);
  assign bus_run  = run & bus_edge;                        // RQ5
  assign sole_run = bus_run & OTHER_HALTED;                // RQ6

  // a trip is each rise above the threshold, not the time spent above;
  // a rise while already throttled is counted but keeps the timer
  assign trip_p = rise_of(OVER_TRIP, trip_seen_r);         // RQ1

  // the sample timer runs only while throttled, so the first check
  // comes one full period after the trip; the timer is 16 bits wide,
  // which bounds SAMPLE_CYC to 65536
  assign sample_due = (tick_r == 16'(SAMPLE_CYC - 1));

  // throttle state: enter on a trip, leave at a sample found cool
  always_comb begin
    th_nxt   = th_r;
    tick_nxt = CECS_CNT_RST;
    case (th_r)
      CECS_TH_NORMAL: begin
        if (trip_p) begin
          th_nxt = CECS_TH_THROTTLE;                       // RQ2
        end
      end
      CECS_TH_THROTTLE: begin
        if (!sample_due) begin
          tick_nxt = tick_r + 16'h0001;
        end else if (!OVER_TRIP) begin
          th_nxt = CECS_TH_NORMAL;                         // RQ2
        end
      end
      default: begin
        th_nxt = CECS_TH_NORMAL;
      end
    endcase
    // output follows the state the register is about to take
    throttle_nxt = (th_nxt == CECS_TH_THROTTLE);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      th_r       <= CECS_TH_NORMAL;
      tick_r     <= CECS_CNT_RST;
      throttle_r <= 1'b0;
    end else begin
      th_r       <= th_nxt;
      tick_r     <= tick_nxt;
      throttle_r <= throttle_nxt;
    end
  end

  // the matcher is combinational; an increment shows one clock later
  cecs_match cecs_match_i (
    .sel            (sel),
    .thermal_trip_p (trip_p),
    .core_cyc       (run),
    .bus_cyc        (bus_run),
    .sole_bus_cyc   (sole_run),
    .rd_p           (RD_VALID),
    .wr_p           (WR_VALID),
    .lock_p         (LOCKED),
    .line_state     (LINE_STATE)
  );

  // the count wraps at its full width; no overflow flag is kept
  assign count_inc = COUNT_EN & sel.hit;

  always_comb begin
    count_nxt = count_step(count_r, COUNT_CLR, count_inc);      // RQ10
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_r <= CECS_COUNT_RST;
    end else begin
      count_r <= count_nxt;
    end
  end

  // all three outputs come straight from flip-flops
  assign COUNT    = count_r;
  assign THROTTLE = throttle_r;
  assign HALTED   = halted_r;
endmodule

// ### sim/cecs_chk.sv
// checker: port timing checks for the event selector
module cecs_chk (
  input wire logic        CLK,          // clock
  input wire logic        RESET_N,      // reset
  input wire logic [7:0]  EVENT_CODE,   // event
  input wire logic [7:0]  UNIT_MASK,    // umask
  input wire logic        COUNT_EN,     // enable
  input wire logic        COUNT_CLR,    // clear
  input wire logic        OVER_TRIP,    // hot
  input wire logic        HALT_EXEC,    // halt
  input wire logic        WAKE,         // wake
  input wire logic        OTHER_HALTED, // other
  input wire logic        BUS_CLK,      // bus
  input wire logic        LOCKED,       // lock
  input wire logic [47:0] COUNT,        // count
  input wire logic        THROTTLE,     // slow
  input wire logic        HALTED        // halted
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic [47:0] prev_r;
  always_ff @(posedge CLK) prev_r <= COUNT;
  wire logic run  = COUNT_EN && !COUNT_CLR;
  wire logic un   = run && EVENT_CODE == 8'h3C;
  wire logic act  = !HALTED && !HALT_EXEC;
  wire logic inc  = COUNT == prev_r + 48'h1;
  wire logic same = COUNT == prev_r;
  property p_core; un && UNIT_MASK == 8'h00 && act |=> inc; endproperty
  a_core: assert property (p_core) else $error("core miss");
  property p_halt; un && UNIT_MASK == 8'h00 &&
    (HALT_EXEC || HALTED && !WAKE) |=> same; endproperty
  a_halt: assert property (p_halt) else $error("halt counted");
  property p_bus; un && UNIT_MASK == 8'h01 && act && $rose(BUS_CLK)
    |=> inc; endproperty
  a_bus: assert property (p_bus) else $error("bus miss");
  property p_sole; un && UNIT_MASK == 8'h02 && !OTHER_HALTED |=> same;
  endproperty
  a_sole: assert property (p_sole) else $error("sole counted");
  property p_trip; run && EVENT_CODE == 8'h3B && $rose(OVER_TRIP)
    |=> inc; endproperty
  a_trip: assert property (p_trip) else $error("trip miss");
  property p_thr; $rose(OVER_TRIP) |=> THROTTLE; endproperty
  a_thr: assert property (p_thr) else $error("no throttle");
  property p_hold; THROTTLE && OVER_TRIP |=> THROTTLE; endproperty
  a_hold: assert property (p_hold) else $error("early recover");
  property p_lock; run && EVENT_CODE == 8'h40 && LOCKED |=> same;
  endproperty
  a_lock: assert property (p_lock) else $error("lock counted");
  property p_solecnt; un && UNIT_MASK == 8'h02 && act && OTHER_HALTED &&
    $rose(BUS_CLK) |=> inc; endproperty
  a_solecnt: assert property (p_solecnt) else $error("sole miss");
  property p_unlisted; un && UNIT_MASK > 8'h02 |=> same; endproperty
  a_unlisted: assert property (p_unlisted) else $error("bad umask");
endmodule
bind cecs_top cecs_chk cecs_chk_i (.CLK, .RESET_N, .EVENT_CODE,
  .UNIT_MASK, .COUNT_EN, .COUNT_CLR, .OVER_TRIP, .HALT_EXEC, .WAKE,
  .OTHER_HALTED, .BUS_CLK, .LOCKED, .COUNT, .THROTTLE, .HALTED);

// ### sim/cecs_top_test.sv
// bench: directed scenarios for the event selector
module cecs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 0, RESET_N = 0, COUNT_EN = 0, COUNT_CLR = 0;
  logic        OVER_TRIP = 0, HALT_EXEC = 0, WAKE = 0, OTHER_HALTED = 0;
  logic        BUS_CLK = 0, RD_VALID = 0, WR_VALID = 0, LOCKED = 0;
  logic [7:0]  EVENT_CODE = 8'h00, UNIT_MASK = 8'h00;
  logic [3:0]  LINE_STATE = 4'h1;
  logic [47:0] COUNT;
  logic        THROTTLE, HALTED;
  int          n_mismatch = 0, compares = 0, cyc = 0;
  cecs_top #(.SAMPLE_CYC(8)) cecs_top_i (.CLK, .RESET_N, .EVENT_CODE,
    .UNIT_MASK, .COUNT_EN, .COUNT_CLR, .OVER_TRIP, .HALT_EXEC, .WAKE,
    .OTHER_HALTED, .BUS_CLK, .RD_VALID, .WR_VALID, .LOCKED, .LINE_STATE,
    .COUNT, .THROTTLE, .HALTED);
  always #12.5 CLK = ~CLK;
  task final_report;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      final_report();
    end
  end
  task step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task chk(input logic [47:0] got, exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // clear wins over the increment in the same cycle
  task prep(input logic [7:0] c, m);
    EVENT_CODE = c;
    UNIT_MASK = m;
    COUNT_EN = 1;
    COUNT_CLR = 1;
    step(1);
    COUNT_CLR = 0;
  endtask
  task bus(input int n);
    repeat (n) begin
      BUS_CLK = 1;
      step(1);
      BUS_CLK = 0;
      step(1);
    end
  endtask
  task acc(input logic [7:0] c, input logic r, w, l,
           input logic [3:0] s, input logic [47:0] e);
    prep(c, 8'h03);
    {RD_VALID, WR_VALID, LOCKED, LINE_STATE} = {r, w, l, s};
    step(2);
    {RD_VALID, WR_VALID, LOCKED} = 3'h0;
    step(1);
    chk(COUNT, e);
  endtask
  task t_core;
    prep(8'h3C, 8'h00);
    step(5);
    chk(COUNT, 5);
    HALT_EXEC = 1;
    step(1);
    HALT_EXEC = 0;
    step(3);
    chk(COUNT, 5);
    chk(HALTED, 1);
    WAKE = 1;
    step(1);
    WAKE = 0;
    step(2);
    chk(COUNT, 7);
    chk(HALTED, 0);
    $display("core test done");
  endtask
  task t_bus;
    prep(8'h3C, 8'h01);
    bus(3);
    chk(COUNT, 3);
    prep(8'h3C, 8'h02);
    OTHER_HALTED = 1;
    bus(2);
    OTHER_HALTED = 0;
    bus(2);
    chk(COUNT, 2);
    prep(8'h3C, 8'h03);
    bus(2);
    chk(COUNT, 0);
    $display("bus test done");
  endtask
  task t_cache;
    acc(8'h40, 1, 0, 0, 4'h1, 2);
    acc(8'h40, 1, 0, 1, 4'h1, 0);
    acc(8'h40, 1, 0, 0, 4'h4, 0);
    acc(8'h41, 0, 1, 0, 4'h2, 2);
    acc(8'h41, 0, 1, 1, 4'h2, 0);
    acc(8'h42, 1, 0, 1, 4'h1, 2);
    acc(8'h42, 1, 0, 0, 4'h1, 0);
    $display("cache test done");
  endtask
  task t_trip;
    int i;
    prep(8'h3B, 8'hC0);
    OVER_TRIP = 1;
    step(1);
    chk(COUNT, 1);
    step(20);
    chk(THROTTLE, 1);
    OVER_TRIP = 0;
    for (i = 0; i < 12 && THROTTLE; i++) step(1);
    chk(THROTTLE, 0);
    // cool found only at the third sample point, 24 cycles after the trip
    chk(i, 4);
    OVER_TRIP = 1;
    step(1);
    chk(COUNT, 2);
    $display("trip test done");
  endtask
  initial begin
    step(4);
    RESET_N = 1;
    step(1);
    t_core();
    t_bus();
    t_cache();
    t_trip();
    final_report();
  end
endmodule
